// ### common/port_b_pkg.sv
// constants, register map and state types for the second gpio port
package port_b_pkg;
   localparam int PORT_W = 8;
   localparam int ANA_W = 6;
   localparam int ADDR_W = 4;
   localparam int STAT_W = 2;

   // register offsets (word index on the plain register port)
   localparam logic [3:0] ADR_PINS = 4'h0;
   localparam logic [3:0] ADR_DIR = 4'h1;
   localparam logic [3:0] ADR_PULLUP = 4'h2;
   localparam logic [3:0] ADR_IOC = 4'h3;
   localparam logic [3:0] ADR_ANSEL_HI = 4'h4;
   localparam logic [3:0] ADR_OPTION = 4'h5;
   localparam logic [3:0] ADR_IRQ_STAT = 4'h6;
   localparam logic [3:0] ADR_IRQ_MASK = 4'h7;

   // option control register fields
   localparam int OPT_GPD_BIT = 7;
   localparam int OPT_EDGE_BIT = 6;
   // interrupt status fields
   localparam int ST_CHANGE_BIT = 0;
   localparam int ST_EDGE_BIT = 1;
   // pin 0 doubles as the external edge interrupt input
   localparam int EXT_PIN = 0;

   // reset values
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_PULLUP = 8'hFF;
   localparam logic [7:0] RST_IOC = 8'h00;
   localparam logic [5:0] RST_ANSEL_HI = 6'h3F;
   localparam logic [7:0] RST_SYNC = 8'h00;
   localparam logic [1:0] RST_STAT = 2'h0;
   localparam logic [7:0] ZERO8 = 8'h00;

   // analog select bit index (channel minus 8) that serves each of pins 0 to 5
   localparam int AN_PIN0 = 4;
   localparam int AN_PIN1 = 2;
   localparam int AN_PIN2 = 0;
   localparam int AN_PIN3 = 1;
   localparam int AN_PIN4 = 3;
   localparam int AN_PIN5 = 5;

   typedef struct packed {
      logic global_pullup_disable;
      logic rising_edge_sel;
   } option_type;

   typedef struct packed {
      logic [7:0] out_latch;
      logic [7:0] direction_bits;
      logic [7:0] pullup_bits;
      logic [7:0] ioc_bits;
      logic [5:0] analog_select_bits;
      option_type option;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] sync3;
      logic [7:0] pin_level;
      logic [7:0] rdata;
   } state_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;
endpackage

// ### design/port_b_gpio.sv
// eight-bit gpio port with analog select, weak pull-ups and change interrupt
// Function
// - analog select bits pick analog per pin
// - bits 7:6 of analog select read zero
// - analog pin: no input, pull-up, change detect
// - analog pins read as zero
// - port read returns pin logic levels
// - direction 1 tri-states, 0 drives; resets ones
// - pull-up enable bits, reset all ones
// - pull-ups need global disable cleared
// - output pins never get pull-up
// - change enable bits per pin, reset zero
// - port write stores into output latch
// - pin 0 is external edge interrupt
// - mismatch against last-read latch sets flag
// - port access ends mismatch; mismatch keeps setting
// - last-read latch survives device reset
// - analog select leaves output drive alone
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module port_b_gpio
   import port_b_pkg::*;
(
   // clock and resets
   input wire logic core_clk,
   input wire logic rst,
   input wire logic por_rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [PORT_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PORT_W-1:0] reg_rdata,
   // pins
   input wire logic [PORT_W-1:0] pin_in,
   output logic [PORT_W-1:0] pin_out,
   output logic [PORT_W-1:0] pin_oe,
   output logic [PORT_W-1:0] pin_pullup,
   output logic [PORT_W-1:0] pin_analog,
   // interrupt
   output logic irq
);

   state_type st_ff;
   state_type nxt_st;
   logic [PORT_W-1:0] last_read_ff;
   logic [PORT_W-1:0] nxt_last_read;
   logic [PORT_W-1:0] analog_pins;
   logic [PORT_W-1:0] din;
   logic [PORT_W-1:0] mismatch_bits;
   logic mismatch;
   logic ext_edge;
   logic ext_rise;
   logic ext_fall;
   logic pins_access;

   // map analog select bits onto the pins they serve
   function automatic logic [PORT_W-1:0] pin_analog_map(input logic [ANA_W-1:0] ans);
      logic [PORT_W-1:0] m;
      m = ZERO8;
      m[0] = ans[AN_PIN0];
      m[1] = ans[AN_PIN1];
      m[2] = ans[AN_PIN2];
      m[3] = ans[AN_PIN3];
      m[4] = ans[AN_PIN4];
      m[5] = ans[AN_PIN5];
      return m;
   endfunction

   function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
      return a == ref_a;
   endfunction

   // analog pins lose their digital input path
   assign analog_pins = pin_analog_map(st_ff.analog_select_bits);
   assign din = st_ff.pin_level & ~analog_pins;
   assign pins_access = (reg_rd | reg_wr) & is_addr(reg_addr, ADR_PINS);

   // change detection against value latched on the last port access
   assign mismatch_bits = (din ^ last_read_ff) & st_ff.ioc_bits & ~analog_pins;
   assign mismatch = |mismatch_bits;

   // pin 0 edge taken where the settled level moves, so filtered glitches never flag
   assign ext_rise = ~st_ff.pin_level[EXT_PIN] & st_ff.sync2[EXT_PIN] & st_ff.sync3[EXT_PIN];
   assign ext_fall = st_ff.pin_level[EXT_PIN] & ~st_ff.sync2[EXT_PIN] & ~st_ff.sync3[EXT_PIN];
   // an analog pin 0 has no digital input, so it cannot flag an edge
   assign ext_edge = ~analog_pins[EXT_PIN] &
                     (st_ff.option.rising_edge_sel ? ext_rise : ext_fall);


   always_comb begin
      nxt_st = st_ff;
      // three-stage input sampling; level moves once stages two and three agree
      nxt_st.sync1 = pin_in;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sync3 = st_ff.sync2;
      for (int i = 0; i < PORT_W; i++) begin
         if (st_ff.sync2[i] == st_ff.sync3[i]) begin
            nxt_st.pin_level[i] = st_ff.sync3[i];
         end
      end
      nxt_st.rdata = ZERO8;
      if (reg_wr) begin
         unique case (reg_addr)
            ADR_PINS: begin
               nxt_st.out_latch = reg_wdata;
            end
            ADR_DIR: begin
               nxt_st.direction_bits = reg_wdata;
            end
            ADR_PULLUP: begin
               nxt_st.pullup_bits = reg_wdata;
            end
            ADR_IOC: begin
               nxt_st.ioc_bits = reg_wdata;
            end
            ADR_ANSEL_HI: begin
               nxt_st.analog_select_bits = reg_wdata[ANA_W-1:0];
            end
            ADR_OPTION: begin
               nxt_st.option.global_pullup_disable = reg_wdata[OPT_GPD_BIT];
               nxt_st.option.rising_edge_sel = reg_wdata[OPT_EDGE_BIT];
            end
            ADR_IRQ_STAT: begin
               nxt_st.irq_status = st_ff.irq_status & ~reg_wdata[STAT_W-1:0];
            end
            ADR_IRQ_MASK: begin
               nxt_st.irq_mask = reg_wdata[STAT_W-1:0];
            end
            default: begin
               // unmapped write is dropped
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADR_PINS: nxt_st.rdata = din;
            ADR_DIR: nxt_st.rdata = st_ff.direction_bits;
            ADR_PULLUP: nxt_st.rdata = st_ff.pullup_bits;
            ADR_IOC: nxt_st.rdata = st_ff.ioc_bits;
            ADR_ANSEL_HI: nxt_st.rdata = {2'h0, st_ff.analog_select_bits};
            ADR_OPTION: begin
               nxt_st.rdata[OPT_GPD_BIT] = st_ff.option.global_pullup_disable;
               nxt_st.rdata[OPT_EDGE_BIT] = st_ff.option.rising_edge_sel;
            end
            ADR_IRQ_STAT: nxt_st.rdata = {6'h00, st_ff.irq_status};
            ADR_IRQ_MASK: nxt_st.rdata = {6'h00, st_ff.irq_mask};
            default: nxt_st.rdata = ZERO8;
         endcase
      end
      // events set after any clear, so a simultaneous event survives
      if (mismatch) begin
         nxt_st.irq_status[ST_CHANGE_BIT] = 1'b1;
      end
      if (ext_edge) begin
         nxt_st.irq_status[ST_EDGE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff.out_latch <= RST_LATCH;
         st_ff.direction_bits <= RST_DIR;
         st_ff.pullup_bits <= RST_PULLUP;
         st_ff.ioc_bits <= RST_IOC;
         st_ff.analog_select_bits <= RST_ANSEL_HI;
         st_ff.option.global_pullup_disable <= 1'b1;
         st_ff.option.rising_edge_sel <= 1'b1;
         st_ff.irq_status <= RST_STAT;
         st_ff.irq_mask <= RST_STAT;
         st_ff.sync1 <= RST_SYNC;
         st_ff.sync2 <= RST_SYNC;
         st_ff.sync3 <= RST_SYNC;
         st_ff.pin_level <= RST_SYNC;
         st_ff.rdata <= ZERO8;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // kept outside the main state: only power-on clears it
   always_comb begin
      nxt_last_read = last_read_ff;
      if (pins_access) begin
         nxt_last_read = din;
      end
   end

   always_ff @(posedge core_clk or posedge por_rst) begin
      if (por_rst) begin
         last_read_ff <= RST_SYNC;
      end else begin
         last_read_ff <= nxt_last_read;
      end
   end

   // direction alone gates the driver; analog select does not
   assign pin_oe = ~st_ff.direction_bits;
   assign pin_out = st_ff.out_latch;
   assign pin_pullup = st_ff.pullup_bits & st_ff.direction_bits & ~analog_pins &
                       {PORT_W{~st_ff.option.global_pullup_disable}};
   assign pin_analog = analog_pins;
   assign reg_rdata = st_ff.rdata;
   assign irq = |(st_ff.irq_status & st_ff.irq_mask);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_pins_read;
      reg_rd && is_addr(reg_addr, ADR_PINS);
   endsequence

   sequence s_pins_write;
      reg_wr && is_addr(reg_addr, ADR_PINS);
   endsequence

   sequence s_dir_write;
      reg_wr && is_addr(reg_addr, ADR_DIR);
   endsequence

   sequence s_pullup_write;
      reg_wr && is_addr(reg_addr, ADR_PULLUP);
   endsequence

   sequence s_ansel_write;
      reg_wr && is_addr(reg_addr, ADR_ANSEL_HI);
   endsequence

   sequence s_ioc_write;
      reg_wr && is_addr(reg_addr, ADR_IOC);
   endsequence

   property p_ansel_upper_zero;
      reg_rd && is_addr(reg_addr, ADR_ANSEL_HI) |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_ansel_upper_zero: assert property (p_ansel_upper_zero) else $error("upper analog select bits not zero");

   property p_analog_reads_zero;
      s_pins_read |=> (reg_rdata & $past(analog_pins)) == ZERO8;
   endproperty
   a_analog_reads_zero: assert property (p_analog_reads_zero) else $error("analog pin read as one");

   property p_read_levels;
      s_pins_read |=> reg_rdata == ($past(st_ff.pin_level) & ~$past(analog_pins));
   endproperty
   a_read_levels: assert property (p_read_levels) else $error("port read differs from pin levels");

   property p_write_drives;
      s_pins_write ##1 (!st_ff.direction_bits[0]) |-> pin_out == $past(reg_wdata) && pin_oe[0];
   endproperty
   a_write_drives: assert property (p_write_drives) else $error("written value not driven");

   property p_no_pullup_output;
      (pin_pullup & pin_oe) == ZERO8;
   endproperty
   a_no_pullup_output: assert property (p_no_pullup_output) else $error("pull-up on output pin");

   property p_global_disable;
      st_ff.option.global_pullup_disable |-> pin_pullup == ZERO8;
   endproperty
   a_global_disable: assert property (p_global_disable) else $error("pull-up despite global disable");

   property p_analog_no_pullup;
      (pin_pullup & pin_analog) == ZERO8 && (mismatch_bits & pin_analog) == ZERO8;
   endproperty
   a_analog_no_pullup: assert property (p_analog_no_pullup) else $error("analog pin has digital function");

   property p_change_flag;
      mismatch |=> st_ff.irq_status[ST_CHANGE_BIT];
   endproperty
   a_change_flag: assert property (p_change_flag) else $error("mismatch did not set change flag");

   property p_access_ends;
      s_pins_read ##1 (din == $past(din)) |-> !mismatch;
   endproperty
   a_access_ends: assert property (p_access_ends) else $error("port read left mismatch");

   property p_edge_flag;
      $rose(st_ff.pin_level[EXT_PIN]) && $past(st_ff.option.rising_edge_sel) && !$past(analog_pins[EXT_PIN]) |->
         st_ff.irq_status[ST_EDGE_BIT];
   endproperty
   a_edge_flag: assert property (p_edge_flag) else $error("edge on pin 0 not flagged");

   property p_irq_level;
      (st_ff.irq_status & st_ff.irq_mask) != RST_STAT |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("masked-in status without interrupt");

   property p_edge_fall;
      $fell(st_ff.pin_level[EXT_PIN]) && !$past(st_ff.option.rising_edge_sel) && !$past(analog_pins[EXT_PIN]) |->
         st_ff.irq_status[ST_EDGE_BIT];
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge on pin 0 not flagged");

   // the edge flag must never rise without a settled level move on pin 0
   property p_edge_quiet;
      $rose(st_ff.irq_status[ST_EDGE_BIT]) |-> $changed(st_ff.pin_level[EXT_PIN]);
   endproperty
   a_edge_quiet: assert property (p_edge_quiet) else $error("edge flag without pin 0 edge");

   property p_ioc_gate;
      $rose(st_ff.irq_status[ST_CHANGE_BIT]) |-> $past(|((din ^ last_read_ff) & st_ff.ioc_bits));
   endproperty
   a_ioc_gate: assert property (p_ioc_gate) else $error("change flag from disabled pin");

   property p_dir_write;
      s_dir_write |=> pin_oe == ~$past(reg_wdata);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("driver enable not per direction");

   property p_pullup_write;
      s_pullup_write |=> st_ff.pullup_bits == $past(reg_wdata);
   endproperty
   a_pullup_write: assert property (p_pullup_write) else $error("pull-up enable not stored");

   property p_ansel_write;
      s_ansel_write |=> st_ff.analog_select_bits == $past(reg_wdata[ANA_W-1:0]);
   endproperty
   a_ansel_write: assert property (p_ansel_write) else $error("analog select not stored");

   property p_ansel_keeps_drive;
      s_ansel_write |=> $stable(pin_out) && $stable(pin_oe);
   endproperty
   a_ansel_keeps_drive: assert property (p_ansel_keeps_drive) else $error("analog select moved output");

   property p_ioc_write;
      s_ioc_write |=> st_ff.ioc_bits == $past(reg_wdata);
   endproperty
   a_ioc_write: assert property (p_ioc_write) else $error("change enable not stored");

   property p_latch_load;
      pins_access |=> last_read_ff == $past(din);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("port access did not load latch");

   // checked through device resets too: only power-on or a port access may touch the latch
   property p_latch_hold;
      disable iff (por_rst) !pins_access |=> $stable(last_read_ff);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("last-read latch changed");

   property p_change_clear;
      reg_wr && is_addr(reg_addr, ADR_IRQ_STAT) && reg_wdata[ST_CHANGE_BIT] && !mismatch |=>
         !st_ff.irq_status[ST_CHANGE_BIT];
   endproperty
   a_change_clear: assert property (p_change_clear) else $error("change flag not cleared");
endmodule

// ### design/port_b_gpio_unused_guard.sv
// no logic: every part of the port sits in the main design file

// ### bench/pin_board.sv
// board model: port drivers, external sources and floating lines
`timescale 1ns/1ps
module pin_board (
   // clock
   input wire logic core_clk,
   // from the port
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup,
   // external sources
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   // resolved pin levels
   output logic [7:0] pin_in
);
   logic [7:0] flt_ff = 8'h55;
   // undriven lines toggle so they never pass for a steady level
   always @(posedge core_clk) flt_ff <= ~flt_ff;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pullup[i]) pin_in[i] = 1'b1;
         else pin_in[i] = flt_ff[i];
      end
   end
endmodule

// ### bench/tb.sv
// self-checking bench for the second gpio port
`timescale 1ns/1ps
module tb;
   import port_b_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic por_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pullup, pin_analog;
   logic irq;
   logic [7:0] ext_val = 8'hA5;
   logic [7:0] ext_en = 8'hFF;
   logic rd_q = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] rv[9] = '{8'h80, 8'hFF, 8'hFF, 8'h00, 8'h3F, 8'hC0, 8'h00, 8'h00, 8'h00};
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] v, m;
   logic [5:0] a;

   always #10 core_clk = ~core_clk;

   port_b_gpio i_dut (.core_clk(core_clk), .rst(rst), .por_rst(por_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_analog(pin_analog), .irq(irq));
   pin_board i_board (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   function automatic logic [7:0] ana_pins(input logic [5:0] s);
      ana_pins = 8'h00;
      ana_pins[0] = s[AN_PIN0];
      ana_pins[1] = s[AN_PIN1];
      ana_pins[2] = s[AN_PIN2];
      ana_pins[3] = s[AN_PIN3];
      ana_pins[4] = s[AN_PIN4];
      ana_pins[5] = s[AN_PIN5];
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      exp_q.push_back(exp);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic settle();
      repeat (6) @(posedge core_clk);
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge core_clk) rd_q <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_q) check(reg_rdata, exp_q.pop_front());
      else check(reg_rdata, 8'h00);
   end

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(32'hECD0));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      por_rst <= 1'b0;
      settle();
      foreach (rv[i]) rd(4'(i), rv[i]);
      @(negedge core_clk);
      check(pin_oe, 8'h00);
      check(pin_analog, 8'h3F);
      wr(ADR_ANSEL_HI, 8'hFF);
      rd(ADR_ANSEL_HI, 8'h3F);
      for (int k = 0; k < 4; k++) begin
         a = 6'($urandom);
         v = 8'($urandom);
         wr(ADR_ANSEL_HI, {2'b00, a});
         ext_val <= v;
         settle();
         rd(ADR_PINS, v & ~ana_pins(a));
         @(negedge core_clk);
         check(pin_analog, ana_pins(a));
      end
      // analog pin 4 driven as output on purpose
      v = 8'($urandom);
      wr(ADR_ANSEL_HI, 8'h0F);
      wr(ADR_DIR, 8'h0F);
      wr(ADR_PINS, v);
      @(negedge core_clk);
      check(pin_out, v);
      check(pin_oe, 8'hF0);
      settle();
      rd(ADR_PINS, {v[7:4], ext_val[3:0]} & ~ana_pins(6'h0F));
      for (int k = 0; k < 4; k++) begin
         a = 6'($urandom);
         m = 8'($urandom);
         v = 8'($urandom);
         wr(ADR_OPTION, {k[0], 7'h40});
         wr(ADR_PULLUP, m);
         wr(ADR_DIR, v | ana_pins(a));
         wr(ADR_ANSEL_HI, {2'b00, a});
         @(negedge core_clk);
         check(pin_pullup, k[0] ? 8'h00 : m & v & ~ana_pins(a));
      end
      wr(ADR_DIR, 8'hFF);
      wr(ADR_ANSEL_HI, 8'h00);
      wr(ADR_OPTION, 8'h40);
      wr(ADR_PULLUP, 8'hFF);
      ext_en <= 8'h00;
      settle();
      rd(ADR_PINS, 8'hFF);
      ext_en <= 8'hFF;
      wr(ADR_IOC, 8'hFF);
      wr(ADR_IRQ_MASK, 8'h01);
      settle();
      rd(ADR_PINS, ext_val);
      wr(ADR_IRQ_STAT, 8'h03);
      rd(ADR_IRQ_STAT, 8'h00);
      ext_val <= ext_val ^ 8'h80;
      settle();
      wr(ADR_IRQ_STAT, 8'h01);
      rd(ADR_IRQ_STAT, 8'h01);
      @(negedge core_clk);
      check(8'(irq), 8'h01);
      wr(ADR_IRQ_MASK, 8'h00);
      @(negedge core_clk);
      check(8'(irq), 8'h00);
      wr(ADR_IRQ_MASK, 8'h01);
      rd(ADR_PINS, ext_val);
      wr(ADR_IRQ_STAT, 8'h01);
      rd(ADR_IRQ_STAT, 8'h00);
      wr(ADR_IOC, 8'h7F);
      ext_val <= ext_val ^ 8'h80;
      settle();
      rd(ADR_IRQ_STAT, 8'h00);
      wr(ADR_IOC, 8'h00);
      wr(ADR_IRQ_MASK, 8'h02);
      for (int e = 1; e >= 0; e--) begin
         wr(ADR_OPTION, {2'b01 ^ 2'(e), 6'h00});
         ext_val <= {ext_val[7:1], e[0]};
         settle();
         wr(ADR_IRQ_STAT, 8'h03);
         ext_val <= {ext_val[7:1], ~e[0]};
         settle();
         rd(ADR_IRQ_STAT, 8'h02);
         @(negedge core_clk);
         check(8'(irq), 8'h01);
         wr(ADR_IRQ_STAT, 8'h03);
         ext_val <= {ext_val[7:1], e[0]};
         settle();
         rd(ADR_IRQ_STAT, 8'h00);
      end
      ext_val <= 8'h3C;
      settle();
      rd(ADR_PINS, 8'h3C);
      @(posedge core_clk);
      ext_val <= 8'h00;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      wr(ADR_ANSEL_HI, 8'h00);
      wr(ADR_IOC, 8'hFF);
      wr(ADR_IRQ_MASK, 8'h01);
      settle();
      rd(ADR_IRQ_STAT, 8'h01);
      settle();
      end_of_test();
   end
endmodule
